// >>> rtl/rf_line_coding.sv
`default_nettype none
module rf_line_coding #(
  parameter logic [13:0] VIC_SLOW_PERIOD = rf_coding_pkg::PER_VIC_SLOW
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic carrier_tick,
  input wire logic [1:0] mode,
  input wire logic [1:0] speed,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic tx_bit,
  input wire logic tx_last,
  output logic tx_mod_r,
  output logic tx_full_depth_r,
  output logic tx_busy,
  input wire logic rx_enable,
  input wire logic rx_env,
  input wire logic rx_phase,
  output logic rx_valid_r,
  output logic rx_bit_r,
  output logic rx_err_r,
  output logic rx_bpsk_r
);
  typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX} state_t;
  localparam int PW = rf_coding_pkg::PER_W;

  state_t state_r, state_nxt;
  rf_coding_pkg::rf_mode_t mode_r;
  logic [1:0] speed_r;
  logic cur_bit_r, last_r, prev_one_r, s1_r, s2_r;
  logic [PW-1:0] cnt_w, period_w, half_w, quart_w, per_a_w, per_man_w, per_vic_w;
  logic bit_end, run_w, start_tx, start_rx, take_next, bpsk_w, rx_src, mod_nxt;
  logic miller_w, manch_w, is_a, is_man;

  assign is_a = (mode_r == rf_coding_pkg::MODE_A);
  assign is_man = (mode_r == rf_coding_pkg::MODE_MAN);

  // Period lookup from the held mode and speed
  assign per_a_w = (speed_r == 2'h0) ? rf_coding_pkg::PER_106 :
                   (speed_r == 2'h1) ? rf_coding_pkg::PER_212 :
                   (speed_r == 2'h2) ? rf_coding_pkg::PER_424 : rf_coding_pkg::PER_848;
  // Out-of-range speeds fold onto the nearest supported rate
  assign per_man_w = speed_r[1] ? rf_coding_pkg::PER_424 : rf_coding_pkg::PER_212;
  assign per_vic_w = (speed_r == 2'h0) ? VIC_SLOW_PERIOD : rf_coding_pkg::PER_VIC_FAST;
  assign period_w = is_man ? per_man_w :
                    (mode_r == rf_coding_pkg::MODE_VIC) ? per_vic_w : per_a_w;
  assign half_w = period_w >> 1;
  assign quart_w = period_w >> 2;

  assign run_w = (state_r != ST_IDLE);
  bit_timer #(.W(PW)) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .run(run_w),
    .carrier_tick(carrier_tick),
    .period(period_w),
    .cnt_r(cnt_w),
    .bit_end(bit_end)
  );

  // Stream hand-off toward the framing UART
  assign start_tx = (state_r == ST_IDLE) && tx_valid;
  assign start_rx = (state_r == ST_IDLE) && !tx_valid && rx_enable;
  assign take_next = (state_r == ST_TX) && bit_end && !last_r && tx_valid;
  assign tx_ready = (state_r == ST_IDLE) || ((state_r == ST_TX) && bit_end && !last_r);
  assign tx_busy = (state_r == ST_TX);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_tx) begin
          state_nxt = ST_TX;
        end else if (start_rx) begin
          state_nxt = ST_RX;
        end
      end
      ST_TX: begin
        // An underrun ends the frame rather than stretching a bit
        if (bit_end && (last_r || !tx_valid)) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_RX: begin
        if (!rx_enable) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Mode and speed are captured once per exchange
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      mode_r <= rf_coding_pkg::MODE_A;
      speed_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      if (start_tx || start_rx) begin
        mode_r <= rf_coding_pkg::rf_mode_t'(mode);
        speed_r <= speed;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_bit_r <= 1'b0;
      last_r <= 1'b0;
      prev_one_r <= 1'b0;
    end else if (start_tx || take_next) begin
      cur_bit_r <= tx_bit;
      last_r <= tx_last;
      // Clear at frame start so a leading zero gets its start pause
      prev_one_r <= start_tx ? 1'b0 : cur_bit_r;
    end
  end

  // Modified Miller: one pauses mid-bit, zero pauses at start unless after a one
  assign miller_w = cur_bit_r ? ((cnt_w >= half_w) && (cnt_w < half_w + quart_w)) :
                    (!prev_one_r && (cnt_w < quart_w));
  assign manch_w = cur_bit_r ? (cnt_w < half_w) : (cnt_w >= half_w);
  assign mod_nxt = (state_r != ST_TX) ? 1'b0 :
                   is_a ? miller_w :
                   is_man ? manch_w : !cur_bit_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_mod_r <= 1'b0;
      tx_full_depth_r <= 1'b0;
    end else begin
      tx_mod_r <= mod_nxt;
      tx_full_depth_r <= is_a;
    end
  end

  // Receive: sample at the quarter and three-quarter points of each bit.
  // The bit grid starts when reception opens; no edge re-alignment is done.
  assign bpsk_w = (is_a && (speed_r != 2'h0)) || (mode_r == rf_coding_pkg::MODE_B);
  assign rx_src = bpsk_w ? rx_phase : rx_env;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else if ((state_r == ST_RX) && carrier_tick) begin
      if (cnt_w == quart_w) begin
        s1_r <= rx_src;
      end
      if (cnt_w == half_w + quart_w) begin
        s2_r <= rx_src;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid_r <= 1'b0;
      rx_bit_r <= 1'b0;
      rx_err_r <= 1'b0;
      rx_bpsk_r <= 1'b0;
    end else begin
      rx_valid_r <= (state_r == ST_RX) && bit_end;
      rx_bpsk_r <= bpsk_w;
      if ((state_r == ST_RX) && bit_end) begin
        rx_bit_r <= s1_r;
        // Manchester needs a transition; BPSK must hold phase through the bit
        rx_err_r <= bpsk_w ? (s1_r != s2_r) : (s1_r == s2_r);
      end
    end
  end

  // Assertion helpers: independent count of carrier ticks per bit
  logic [PW-1:0] tk_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tk_r <= '0;
    end else if (!run_w || bit_end) begin
      tk_r <= '0;
    end else if (carrier_tick) begin
      tk_r <= tk_r + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_tx_accept;
    (state_r == ST_IDLE) && tx_valid;
  endsequence
  sequence s_rx_bit_done;
    (state_r == ST_RX) && bit_end;
  endsequence

  chk_mode_held: assert property ((state_r != ST_IDLE) && $past(state_r != ST_IDLE)
    |-> mode_r == $past(mode_r)) else $error("mode changed inside an exchange");
  chk_miller_depth: assert property ($rose(tx_mod_r) && is_a && (state_r == ST_TX)
    |-> tx_full_depth_r) else $error("type A pause not at full depth");
  chk_a_bit_len: assert property (bit_end && is_a && (state_r == ST_TX)
    |-> tk_r == (rf_coding_pkg::PER_106 >> speed_r) - 1'b1)
    else $error("type A bit length wrong");
  chk_rx_decoder: assert property ($past(is_a) && is_a && rx_valid_r
    |-> rx_bpsk_r == (speed_r != 2'h0)) else $error("type A receive decoder wrong");
  chk_man_bit_len: assert property (bit_end && is_man
    |-> tk_r == (speed_r[1] ? rf_coding_pkg::PER_424 : rf_coding_pkg::PER_212) - 1'b1)
    else $error("Manchester bit length wrong");
  chk_man_depth: assert property (is_man && (state_r == ST_TX) ##1 is_man
    |-> !tx_full_depth_r) else $error("Manchester scheme at full depth");
  chk_tx_handoff: assert property (s_tx_accept |-> tx_ready ##1 (state_r == ST_TX))
    else $error("accepted bit did not start transmission");
  chk_rx_handoff: assert property (s_rx_bit_done |=> rx_valid_r ##1 !rx_valid_r)
    else $error("received bit not a single pulse");
  chk_reload: assert property (bit_end |-> tk_r == period_w - 1'b1 ##1 cnt_w == '0)
    else $error("bit timer not reloaded at bit end");
  // A pause on a zero after a one would read as a start pause at the card
  chk_miller_skip: assert property (is_a && (state_r == ST_TX)
    && prev_one_r && !cur_bit_r |=> !tx_mod_r) else $error("pause on a zero after a one");
  chk_rx_quiet: assert property ($past(state_r) != ST_RX |-> !rx_valid_r)
    else $error("received bit outside a receive window");
endmodule : rf_line_coding
`default_nettype wire

// >>> rtl/rf_coding_pkg.sv
// Summary of operation
// - Four reader modes exist; exactly one of them is held for each exchange.
// - Type A transmit uses full-depth pauses with modified Miller coding at every speed.
// - Type A bit period is 128, 64, 32 or 16 carrier cycles for 106, 212, 424, 848 kbit/s.
// - Type A receive decodes a carrier/16 subcarrier: Manchester at 106 kbit/s, BPSK above.
// - Manchester card scheme: Manchester both ways, 64 or 32 carrier cycles per bit.
// - Manchester card scheme sends partial-depth ASK and accepts shallow load modulation.
// - Type A: UART and CPU run the RF protocol over this bit stream; a host does the rest.
// - Manchester card scheme: UART and CPU run the protocol; a host runs the application.
`default_nettype none
package rf_coding_pkg;
  typedef enum logic [1:0] {MODE_A, MODE_MAN, MODE_B, MODE_VIC} rf_mode_t;
  typedef enum logic [1:0] {SPD_106, SPD_212, SPD_424, SPD_848} rf_speed_t;
  localparam int PER_W = 14;
  localparam logic [PER_W-1:0] PER_106 = 14'h0080;
  localparam logic [PER_W-1:0] PER_212 = 14'h0040;
  localparam logic [PER_W-1:0] PER_424 = 14'h0020;
  localparam logic [PER_W-1:0] PER_848 = 14'h0010;
  localparam logic [PER_W-1:0] PER_VIC_FAST = 14'h0200;
  localparam logic [PER_W-1:0] PER_VIC_SLOW = 14'h2000;
endpackage : rf_coding_pkg
`default_nettype wire

// >>> rtl/bit_timer.sv
`default_nettype none
module bit_timer #(
  parameter int W = 14
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic carrier_tick,
  input wire logic [W-1:0] period,
  output logic [W-1:0] cnt_r,
  output logic bit_end
);
  logic [W-1:0] cnt_nxt;

  assign bit_end = run && carrier_tick && (cnt_r == period - 1'b1);
  // Restart at zero on each bit end and while stopped
  assign cnt_nxt = (!run || bit_end) ? '0 : (carrier_tick ? cnt_r + 1'b1 : cnt_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : bit_timer
`default_nettype wire

// >>> bench/card_model.sv
`default_nettype none
module card_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic carrier_tick,
  input wire logic active,
  input wire logic [13:0] period,
  input wire logic [3:0] bits,
  input wire logic [2:0] bad_idx,
  output logic rx_env,
  output logic rx_phase
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [13:0] cnt_r;
  logic [2:0] idx_r;
  logic tgl_r;
  logic b;
  logic half;
  assign b = bits[idx_r[1:0]];
  assign half = cnt_r >= (period >> 1);
  // Outside the answer the line toggles so a stale level never reads as data
  assign rx_env = !active ? tgl_r : (half && idx_r != bad_idx) ? !b : b;
  assign rx_phase = !active ? tgl_r : b;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 14'h0000;
      idx_r <= 3'h0;
      tgl_r <= 1'b0;
    end else begin
      tgl_r <= !tgl_r;
      if (!active) begin
        cnt_r <= 14'h0000;
        idx_r <= 3'h0;
      end else if (carrier_tick) begin
        cnt_r <= (cnt_r == period - 14'h0001) ? 14'h0000 : cnt_r + 14'h0001;
        if (cnt_r == period - 14'h0001) idx_r <= idx_r + 3'h1;
      end
    end
  end
endmodule : card_model
`default_nettype wire

// >>> bench/rf_line_coding_tb_top.sv
`default_nettype none
module rf_line_coding_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, carrier_tick = 0, tx_valid = 0, tx_bit = 0, tx_last = 0;
  logic rx_enable = 0, rx_env, rx_phase, tx_ready, tx_mod_r, tx_full_depth_r, tx_busy;
  logic rx_valid_r, rx_bit_r, rx_err_r, rx_bpsk_r;
  logic [1:0] mode = 2'h0, speed = 2'h0;
  logic [13:0] per = 14'h0080;
  logic [3:0] bits = 4'h0;
  logic [2:0] bad_idx = 3'h7;
  int bad_count = 0, checks = 0, acc = 0, s;
  always #25 clk = !clk;
  // Carrier ticks at 13.56/20 of the clock rate, at most one per clock
  always @(posedge clk) begin
    #1;
    acc = acc + 1356;
    carrier_tick = acc >= 2000;
    if (acc >= 2000) acc = acc - 2000;
  end
  rf_line_coding #(.VIC_SLOW_PERIOD(14'h0040)) i_rf_line_coding (.clk(clk), .rst_n(rst_n),
    .carrier_tick(carrier_tick), .mode(mode), .speed(speed), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_bit(tx_bit), .tx_last(tx_last), .tx_mod_r(tx_mod_r),
    .tx_full_depth_r(tx_full_depth_r), .tx_busy(tx_busy), .rx_enable(rx_enable),
    .rx_env(rx_env), .rx_phase(rx_phase), .rx_valid_r(rx_valid_r), .rx_bit_r(rx_bit_r),
    .rx_err_r(rx_err_r), .rx_bpsk_r(rx_bpsk_r));
  card_model i_card_model (.clk(clk), .rst_n(rst_n), .carrier_tick(carrier_tick),
    .active(rx_enable), .period(per), .bits(bits), .bad_idx(bad_idx),
    .rx_env(rx_env), .rx_phase(rx_phase));
  task automatic print_verdict;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask : cmp
  task automatic bound(input int k);
    if (k >= 9000) begin
      bad_count++;
      print_verdict();
    end
  endtask : bound
  task automatic tx_one(input logic [1:0] m, input logic [1:0] sp, input logic v,
      input logic fd, input logic [15:0] p, input logic [15:0] mp);
    logic [15:0] nt, nm;
    logic f;
    int k;
    nt = 0;
    nm = 0;
    f = fd;
    k = 0;
    mode = m;
    speed = sp;
    tx_bit = v;
    tx_last = 1;
    tx_valid = 1;
    @(posedge clk);
    #1;
    tx_valid = 0;
    while (tx_busy === 1'b1 && k < 9000) begin
      @(posedge clk);
      nt = nt + 16'(carrier_tick);
      nm = nm + 16'(carrier_tick & tx_mod_r);
      if (tx_mod_r === 1'b1) f = tx_full_depth_r;
      k++;
      #1;
    end
    bound(k);
    // One clock of output lag may move a pause edge across a tick
    if (nm == mp + 16'h0001 || nm + 16'h0001 == mp) nm = mp;
    cmp("bit ticks", p, nt);
    cmp("mod ticks", mp, nm);
    cmp("depth", fd, f);
    cmp("ready", 1'b1, tx_ready);
    $display("test tx mode %0d speed %0d done", m, sp);
  endtask : tx_one
  task automatic rx_run(input logic [1:0] m, input logic [1:0] sp, input logic [13:0] p,
      input logic [3:0] b, input logic [2:0] bad, input logic bp);
    int k;
    mode = m;
    speed = sp;
    per = p;
    bits = b;
    bad_idx = bad;
    rx_enable = 1;
    for (int i = 0; i < 4; i++) begin
      k = 0;
      while (rx_valid_r !== 1'b1 && k < 9000) begin
        @(posedge clk);
        #1;
        k++;
      end
      bound(k);
      cmp("rx bit", b[i], rx_bit_r);
      cmp("rx err", i == bad, rx_err_r);
      cmp("rx bpsk", bp, rx_bpsk_r);
      @(posedge clk);
      #1;
    end
    rx_enable = 0;
    repeat (2) @(posedge clk);
    #1;
    $display("test rx mode %0d speed %0d done", m, sp);
  endtask : rx_run
  task automatic tx_pair;
    logic [15:0] nt, nm, nr;
    int k;
    nt = 0;
    nm = 0;
    nr = 0;
    k = 0;
    mode = 2'h0;
    speed = 2'h3;
    tx_bit = 1;
    tx_last = 0;
    tx_valid = 1;
    @(posedge clk);
    #1;
    // Second bit is a zero after a one, offered until a bit end takes it
    tx_bit = 0;
    tx_last = 1;
    while (tx_busy === 1'b1 && k < 9000) begin
      @(posedge clk);
      nt = nt + 16'(carrier_tick);
      nm = nm + 16'(carrier_tick & tx_mod_r);
      nr = nr + 16'(tx_ready);
      k++;
      #1;
      if (nr != 16'h0000) tx_valid = 0;
    end
    if (nr == 16'h0000) tx_valid = 0;
    bound(k);
    // One clock of output lag may move a pause edge across a tick
    if (nm == 16'h0005 || nm == 16'h0003) nm = 16'h0004;
    cmp("frame ticks", 16'h0020, nt);
    cmp("frame mod ticks", 16'h0004, nm);
    cmp("frame takes", 16'h0001, nr);
    $display("test tx frame done");
  endtask : tx_pair
  initial begin
    repeat (12) @(posedge clk);
    #1;
    cmp("reset ready", 1'b1, tx_ready);
    cmp("reset busy", 1'b0, tx_busy);
    rst_n = 1;
    @(posedge clk);
    #1;
    for (s = 0; s < 4; s++) begin
      tx_one(2'h0, s[1:0], 1'b1, 1'b1, 16'h0080 >> s, 16'h0020 >> s);
    end
    tx_one(2'h0, 2'h0, 1'b0, 1'b1, 16'h0080, 16'h0020);
    tx_one(2'h1, 2'h1, 1'b1, 1'b0, 16'h0040, 16'h0020);
    tx_one(2'h1, 2'h2, 1'b0, 1'b0, 16'h0020, 16'h0010);
    tx_one(2'h2, 2'h3, 1'b0, 1'b0, 16'h0010, 16'h0010);
    tx_one(2'h3, 2'h0, 1'b0, 1'b0, 16'h0040, 16'h0040);
    tx_one(2'h3, 2'h1, 1'b1, 1'b0, 16'h0200, 16'h0000);
    tx_pair();
    rx_run(2'h0, 2'h0, 14'h0080, 4'hB, 3'h7, 1'b0);
    rx_run(2'h0, 2'h1, 14'h0040, 4'h6, 3'h7, 1'b1);
    rx_run(2'h1, 2'h2, 14'h0020, 4'h9, 3'h2, 1'b0);
    rx_run(2'h2, 2'h3, 14'h0010, 4'h5, 3'h7, 1'b1);
    print_verdict();
  end
endmodule : rf_line_coding_tb_top
`default_nettype wire
